// ===== beri_evq_mem.sv
// Small memory holding the pending event codes, registered read.
`default_nettype none
module beri_evq_mem #(
  parameter int W = 8,
  parameter int AW = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Write port
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [W-1:0] wdata_i,
  // Read port
  input wire logic [AW-1:0] raddr_i,
  output logic [W-1:0] rdata_o
);

  logic [W-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // Read sees the old word when written in the same cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= mem[raddr_i];
    end
  end

endmodule
`default_nettype wire

// ===== beri_pkg.sv
// Shared constants and types of the bus event report interpreter.
`default_nettype none
package beri_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int ARG_W = 16;
  localparam int EVT_W = 8;
  localparam int ERR_W = 5;
  localparam int RPL_W = 16;
  localparam int EVENT_COUNT_SETTING_W = 8;

  // ************************************************************
  // Values after reset and thresholds
  // ************************************************************
  // Arguments are signed fixed point with eight fraction bits
  localparam logic signed [ARG_W-1:0] ONOFF_THRESHOLD = 16'sh0080;
  localparam int ARG_FRAC_BITS = 8;
  localparam logic TRIG_EN_RST = 1'b1;
  localparam logic [EVENT_COUNT_SETTING_W-1:0] EVENT_COUNT_SETTING_RST = 8'h00;
  localparam logic [RPL_W-1:0] VAR_EMPTY_QTY = 16'h0001;

  // ************************************************************
  // Error and event codes
  // ************************************************************
  localparam logic [EVT_W-1:0] EVT_NONE = 8'h00;
  localparam logic [EVT_W-1:0] EVT_HEADER = 8'h65;
  localparam logic [EVT_W-1:0] EVT_ARGUMENT = 8'h67;
  localparam logic [EVT_W-1:0] EVT_MISSING_ARG = 8'h6a;
  localparam logic [EVT_W-1:0] EVT_CHECKSUM = 8'h6c;
  localparam logic [EVT_W-1:0] EVT_BYTECOUNT = 8'h6d;
  localparam logic [EVT_W-1:0] EVT_IN_OVERFLOW = 8'h96;
  localparam logic [EVT_W-1:0] EVT_GET_IGNORED = 8'hce;

  localparam logic [ERR_W-1:0] ERR_NONE = 5'h00;
  localparam logic [ERR_W-1:0] ERR_END_IN_BLOCK = 5'h04;
  localparam logic [ERR_W-1:0] ERR_CHECKSUM = 5'h05;
  localparam logic [ERR_W-1:0] ERR_QMARK_PLACE = 5'h06;
  localparam logic [ERR_W-1:0] ERR_QUERY_UNKNOWN = 5'h07;
  localparam logic [ERR_W-1:0] ERR_HEADER_UNKNOWN = 5'h08;
  localparam logic [ERR_W-1:0] ERR_ARGS_MISSING = 5'h09;
  localparam logic [ERR_W-1:0] ERR_CHAR_ARG = 5'h0a;
  localparam logic [ERR_W-1:0] ERR_IN_OVERFLOW = 5'h18;

  // ************************************************************
  // Commands, states and carriers
  // ************************************************************
  typedef enum logic [3:0] {
    OP_SET_TRIG    = 4'h0,
    OP_SET_EVENT_COUNT_SETTING   = 4'h1,
    OP_Q_TRIG      = 4'h2,
    OP_Q_EVENT_COUNT_SETTING     = 4'h3,
    OP_Q_EVENT     = 4'h4,
    OP_Q_ALL_EVENTS_QUERY     = 4'h5,
    OP_Q_EVENT_QUANTITY_QUERY     = 4'h6,
    OP_Q_TEST      = 4'h7,
    OP_Q_ERR       = 4'h8
  } beri_op_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_FETCH = 3'b001,
    ST_SEND  = 3'b010,
    ST_TWAIT = 3'b011,
    ST_ERR   = 3'b100,
    ST_TRAM  = 3'b101
  } beri_state_t;

  typedef struct packed {
    beri_op_t op;
    logic signed [ARG_W-1:0] arg;
  } beri_cmd_t;

  typedef struct packed {
    logic [RPL_W-1:0] data;
    logic last;
  } beri_reply_t;

endpackage
`default_nettype wire

// ===== beri_test_engine_model.sv
// Behavioural model of the memory self-test engine that answers the interpreter.
`default_nettype none
module beri_test_engine_model #(
  parameter int PARTS = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Request and answer
  input wire logic start_i,
  output logic done_o,
  output logic [PARTS-1:0] rom_bad_o,
  output logic [PARTS-1:0] ram_bad_o,
  // Scenario control
  input wire logic [3:0] delay_i,
  input wire logic [PARTS-1:0] rom_mask_i,
  input wire logic [PARTS-1:0] ram_mask_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy_reg;
  logic [3:0] cnt_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_reg <= 1'b0;
      cnt_reg <= 4'h0;
      done_o <= 1'b0;
      rom_bad_o <= '0;
      ram_bad_o <= '0;
    end else begin
      done_o <= 1'b0;
      if (start_i && !busy_reg) begin
        busy_reg <= 1'b1;
        cnt_reg <= delay_i;
      end else if (busy_reg && cnt_reg != 4'h0) begin
        cnt_reg <= cnt_reg - 4'h1;
      end else if (busy_reg) begin
        busy_reg <= 1'b0;
        done_o <= 1'b1;
        rom_bad_o <= rom_mask_i;
        ram_bad_o <= ram_mask_i;
      end
      // Masks are only valid with done, so they turn to garbage right after
      if (done_o) begin
        rom_bad_o <= ~rom_bad_o;
        ram_bad_o <= ~ram_bad_o;
      end
    end
  end
endmodule
`default_nettype wire

// ===== beri_top.sv
// Command interpreter for trigger, event report, self-test and error queries.
`default_nettype none
module beri_top
  import beri_pkg::*;
#(
  parameter int EVQ_AW = 4,
  parameter int ROM_PARTS = 16,
  parameter int RAM_PARTS = 16
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // Parsed commands
  input wire logic CMD_VALID_I,
  input wire beri_cmd_t CMD_I,
  output logic CMD_READY_O,
  // Replies
  output logic REPLY_VALID_O,
  output beri_reply_t REPLY_O,
  input wire logic REPLY_READY_I,
  // Trigger message and sweep
  input wire logic GET_I,
  output logic SWEEP_START_O,
  // Parser errors
  input wire logic ERR_VALID_I,
  input wire logic [ERR_W-1:0] ERR_CODE_I,
  // Events from the rest of the device
  input wire logic EXT_EVT_VALID_I,
  input wire logic [EVT_W-1:0] EXT_EVT_CODE_I,
  output logic EXT_EVT_ACCEPT_O,
  // Memory self-test engine
  output logic TEST_START_O,
  input wire logic TEST_DONE_I,
  input wire logic [ROM_PARTS-1:0] TEST_ROM_BAD_I,
  input wire logic [RAM_PARTS-1:0] TEST_RAM_BAD_I,
  // Status
  output logic [EVQ_AW:0] EVT_PENDING_O
);

  // ************************************************************
  // Decoding functions
  // ************************************************************
  function automatic logic [EVT_W-1:0] err_to_evt(input logic [ERR_W-1:0] code);
    logic [EVT_W-1:0] evt;
    evt = EVT_ARGUMENT;
    unique case (code)
      ERR_END_IN_BLOCK: evt = EVT_BYTECOUNT;
      ERR_CHECKSUM: evt = EVT_CHECKSUM;
      ERR_QUERY_UNKNOWN, ERR_HEADER_UNKNOWN: evt = EVT_HEADER;
      ERR_ARGS_MISSING: evt = EVT_MISSING_ARG;
      ERR_IN_OVERFLOW: evt = EVT_IN_OVERFLOW;
      default: evt = EVT_ARGUMENT;
    endcase
    return evt;
  endfunction

  function automatic logic [ERR_W-1:0] lowest_err(input logic [31:0] bits);
    logic [ERR_W-1:0] res;
    res = ERR_NONE;
    for (int i = 31; i >= 1; i--) begin
      if (bits[i]) begin
        res = i[ERR_W-1:0];
      end
    end
    return res;
  endfunction

  localparam int DEPTH = 1 << EVQ_AW;

  // ************************************************************
  // Registers
  // ************************************************************
  beri_state_t state_reg, state_next, ret_reg, ret_next;
  beri_reply_t reply_reg, reply_next;
  logic reply_valid_reg, reply_valid_next;
  logic trig_en_reg, trig_en_next;
  logic [EVENT_COUNT_SETTING_W-1:0] event_count_setting_reg, event_count_setting_next;
  logic [RPL_W-1:0] remain_reg, remain_next;
  logic [RAM_PARTS-1:0] ram_bad_reg, ram_bad_next;
  logic [31:0] err_bits_reg;
  logic [EVQ_AW:0] count_reg;
  logic [EVQ_AW-1:0] wr_ptr_reg, rd_ptr_reg;
  logic get_pend_reg, head_ok_reg, sweep_reg, test_start_reg, ext_acc_reg, cmd_ready_reg;
  logic test_start_next;
  logic pop;
  logic [31:0] err_clr;
  logic [EVT_W-1:0] rd_data;

  // ************************************************************
  // Event store input selection
  // ************************************************************
  // One code enters per cycle; a parser error has priority, an ignored
  // trigger waits in its own flag, outside events are offered back.
  wire logic full = (count_reg == DEPTH[EVQ_AW:0]);
  wire logic take_206 = !ERR_VALID_I && get_pend_reg;
  wire logic take_ext = !ERR_VALID_I && !get_pend_reg && EXT_EVT_VALID_I && !full;
  wire logic push_req = ERR_VALID_I || get_pend_reg || EXT_EVT_VALID_I;
  wire logic push_ok = push_req && !full;
  wire logic [EVT_W-1:0] push_data = ERR_VALID_I ? err_to_evt(ERR_CODE_I) :
                                      get_pend_reg ? EVT_GET_IGNORED :
                                      EXT_EVT_CODE_I;
  wire logic get_fire = GET_I && trig_en_reg;
  wire logic get_ignored = GET_I && !trig_en_reg;
  // Setting the flag wins over taking it into the store
  wire logic get_pend_next = (get_pend_reg && !(take_206 && !full)) || get_ignored;
  wire logic [31:0] err_set = ERR_VALID_I ? (32'h1 << ERR_CODE_I) : 32'h0;
  wire logic [31:0] err_bits_next = (err_bits_reg & ~err_clr) | err_set;
  wire logic [EVQ_AW:0] count_next = count_reg + {{EVQ_AW{1'b0}}, push_ok}
                                     - {{EVQ_AW{1'b0}}, pop};

  // ************************************************************
  // Reply length and argument decoding
  // ************************************************************
  wire logic [RPL_W-1:0] var_qty = (count_reg == '0) ? VAR_EMPTY_QTY :
                                   {{(RPL_W-EVQ_AW-1){1'b0}}, count_reg};
  wire logic [RPL_W-1:0] qty = (event_count_setting_reg != '0) ? {{(RPL_W-EVENT_COUNT_SETTING_W){1'b0}}, event_count_setting_reg} :
                               var_qty;
  wire logic arg_on = (CMD_I.arg >= ONOFF_THRESHOLD);
  wire logic [ARG_W-1:0] arg_int = ARG_W'(CMD_I.arg >>> ARG_FRAC_BITS);
  wire logic [EVENT_COUNT_SETTING_W-1:0] arg_count = CMD_I.arg[ARG_W-1] ? '0 : arg_int[EVENT_COUNT_SETTING_W-1:0];
  wire logic cmd_take = CMD_VALID_I && cmd_ready_reg;
  wire logic [ERR_W-1:0] err_low = lowest_err(err_bits_reg);
  wire logic [31:0] err_low_mask = (err_low == ERR_NONE) ? 32'h0 : (32'h1 << err_low);
  wire logic err_more = ((err_bits_reg & ~err_low_mask) != 32'h0);

  // ************************************************************
  // Reply sequencer
  // ************************************************************
  always_comb begin
    state_next = state_reg;
    ret_next = ret_reg;
    reply_next = reply_reg;
    reply_valid_next = reply_valid_reg;
    trig_en_next = trig_en_reg;
    event_count_setting_next = event_count_setting_reg;
    remain_next = remain_reg;
    ram_bad_next = ram_bad_reg;
    test_start_next = 1'b0;
    pop = 1'b0;
    err_clr = 32'h0;
    unique case (state_reg)
      ST_IDLE: begin
        if (cmd_take) begin
          unique case (CMD_I.op)
            OP_SET_TRIG: trig_en_next = arg_on;
            OP_SET_EVENT_COUNT_SETTING: event_count_setting_next = arg_count;
            OP_Q_TRIG, OP_Q_EVENT_COUNT_SETTING, OP_Q_EVENT_QUANTITY_QUERY: begin
              reply_next.data = (CMD_I.op == OP_Q_TRIG) ? {{(RPL_W-1){1'b0}}, trig_en_reg} :
                                (CMD_I.op == OP_Q_EVENT_COUNT_SETTING) ?
                                {{(RPL_W-EVENT_COUNT_SETTING_W){1'b0}}, event_count_setting_reg} : qty;
              reply_next.last = 1'b1;
              reply_valid_next = 1'b1;
              ret_next = ST_IDLE;
              state_next = ST_SEND;
            end
            // The mask for service requests plays no part here
            OP_Q_EVENT: begin
              remain_next = VAR_EMPTY_QTY;
              state_next = ST_FETCH;
            end
            OP_Q_ALL_EVENTS_QUERY: begin
              remain_next = qty;
              state_next = ST_FETCH;
            end
            OP_Q_TEST: begin
              test_start_next = 1'b1;
              state_next = ST_TWAIT;
            end
            OP_Q_ERR: state_next = ST_ERR;
            default: state_next = ST_IDLE;
          endcase
        end
      end
      ST_FETCH: begin
        // Zero padding once the store runs dry
        reply_next.data = head_ok_reg ? {{(RPL_W-EVT_W){1'b0}}, rd_data} : '0;
        pop = head_ok_reg;
        reply_next.last = (remain_reg == VAR_EMPTY_QTY);
        reply_valid_next = 1'b1;
        remain_next = remain_reg - VAR_EMPTY_QTY;
        ret_next = (remain_reg == VAR_EMPTY_QTY) ? ST_IDLE : ST_FETCH;
        state_next = ST_SEND;
      end
      ST_SEND: begin
        if (REPLY_READY_I) begin
          reply_valid_next = 1'b0;
          state_next = ret_reg;
        end
      end
      ST_TWAIT: begin
        if (TEST_DONE_I) begin
          reply_next.data = RPL_W'(TEST_ROM_BAD_I);
          reply_next.last = 1'b0;
          reply_valid_next = 1'b1;
          ram_bad_next = TEST_RAM_BAD_I;
          ret_next = ST_TRAM;
          state_next = ST_SEND;
        end
      end
      ST_TRAM: begin
        reply_next.data = RPL_W'(ram_bad_reg);
        reply_next.last = 1'b1;
        reply_valid_next = 1'b1;
        ret_next = ST_IDLE;
        state_next = ST_SEND;
      end
      ST_ERR: begin
        reply_next.data = {{(RPL_W-ERR_W){1'b0}}, err_low};
        err_clr = err_low_mask;
        reply_next.last = !err_more;
        reply_valid_next = 1'b1;
        ret_next = err_more ? ST_ERR : ST_IDLE;
        state_next = ST_SEND;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // ************************************************************
  // Flip-flops
  // ************************************************************
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_reg <= ST_IDLE;
      ret_reg <= ST_IDLE;
      reply_reg <= '0;
      reply_valid_reg <= 1'b0;
      trig_en_reg <= TRIG_EN_RST;
      event_count_setting_reg <= EVENT_COUNT_SETTING_RST;
      remain_reg <= '0;
      ram_bad_reg <= '0;
      cmd_ready_reg <= 1'b0;
      test_start_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ret_reg <= ret_next;
      reply_reg <= reply_next;
      reply_valid_reg <= reply_valid_next;
      trig_en_reg <= trig_en_next;
      event_count_setting_reg <= event_count_setting_next;
      remain_reg <= remain_next;
      ram_bad_reg <= ram_bad_next;
      cmd_ready_reg <= (state_next == ST_IDLE);
      test_start_reg <= test_start_next;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      count_reg <= '0;
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      head_ok_reg <= 1'b0;
      get_pend_reg <= 1'b0;
      err_bits_reg <= 32'h0;
      sweep_reg <= 1'b0;
      ext_acc_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      wr_ptr_reg <= wr_ptr_reg + EVQ_AW'(push_ok);
      rd_ptr_reg <= rd_ptr_reg + EVQ_AW'(pop);
      // Lags the count by one edge so it matches the registered read word
      head_ok_reg <= (count_reg != '0) && !pop;
      get_pend_reg <= get_pend_next;
      err_bits_reg <= err_bits_next;
      sweep_reg <= get_fire;
      ext_acc_reg <= take_ext;
    end
  end

  beri_evq_mem #(
    .W(EVT_W),
    .AW(EVQ_AW)
  ) u_evq_mem (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .we_i(push_ok),
    .waddr_i(wr_ptr_reg),
    .wdata_i(push_data),
    .raddr_i(rd_ptr_reg),
    .rdata_o(rd_data)
  );

  assign CMD_READY_O = cmd_ready_reg;
  assign REPLY_VALID_O = reply_valid_reg;
  assign REPLY_O = reply_reg;
  assign SWEEP_START_O = sweep_reg;
  assign EXT_EVT_ACCEPT_O = ext_acc_reg;
  assign TEST_START_O = test_start_reg;
  assign EVT_PENDING_O = count_reg;

  // ************************************************************
  // Assertions
  // ************************************************************
  sequence s_get_ignored;
    GET_I && !trig_en_reg && !ERR_VALID_I;
  endsequence

  sequence s_206_stored;
    push_ok && (push_data == EVT_GET_IGNORED);
  endsequence

  AST_GET_SWEEP: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    GET_I && trig_en_reg |=> SWEEP_START_O)
    else $error("enabled trigger did not start a sweep");

  AST_GET_NO_SWEEP: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    GET_I && !trig_en_reg |=> !SWEEP_START_O)
    else $error("disabled trigger started a sweep");

  AST_GET_206: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    s_get_ignored ##1 (!ERR_VALID_I && !full) |-> s_206_stored)
    else $error("ignored trigger not logged as 206");

  AST_ONOFF: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    cmd_take && CMD_I.op == OP_SET_TRIG |=> trig_en_reg == ($past(CMD_I.arg) >= 16'sh0080))
    else $error("on/off threshold wrong");

  AST_RESET_TRIG: assert property (@(posedge CLK_I)
    $rose(RST_N_I) |-> trig_en_reg)
    else $error("trigger enable not on after reset");

  AST_EVENT_POP: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    state_reg == ST_FETCH && head_ok_reg && !push_ok |=> count_reg == $past(count_reg) - 1'b1)
    else $error("replied event not removed");

  AST_ALL_EVENTS_QUERY_FIXED: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    cmd_take && CMD_I.op == OP_Q_ALL_EVENTS_QUERY && event_count_setting_reg != '0
    |=> remain_reg == {8'h00, $past(event_count_setting_reg)})
    else $error("fixed reply length wrong");

  AST_TEST_ZERO: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    state_reg == ST_TWAIT && TEST_DONE_I && TEST_ROM_BAD_I == '0 && TEST_RAM_BAD_I == '0
    |=> REPLY_VALID_O && REPLY_O.data == 16'h0000 && !REPLY_O.last && ram_bad_reg == '0)
    else $error("good self-test not reported as zero");

  AST_TEST_RAM_ZERO: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    state_reg == ST_TRAM && ram_bad_reg == '0
    |=> REPLY_VALID_O && REPLY_O.data == 16'h0000 && REPLY_O.last)
    else $error("good working memory not reported as zero");

  AST_ERR_ASC: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    state_reg == ST_ERR && err_low != ERR_NONE
    |=> ((($past(err_bits_reg) >> REPLY_O.data[ERR_W-1:0]) & 32'h1) == 32'h1)
        && (($past(err_bits_reg) & ((32'h1 << REPLY_O.data[ERR_W-1:0]) - 32'h2)) == 32'h0)
        && (!err_bits_reg[REPLY_O.data[ERR_W-1:0]] || $past(ERR_VALID_I)))
    else $error("error codes not lowest first");

  AST_ERR9_EVT: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    ERR_VALID_I && ERR_CODE_I == 5'h09 && !full |-> push_ok && push_data == 8'h6a)
    else $error("missing argument not mapped to 106");

endmodule
`default_nettype wire

// ===== tb.sv
// Self-checking testbench of the bus event report interpreter.
`default_nettype none
module tb
  import beri_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [RPL_W-1:0] beri_words_t[$];
  logic clk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, reply_ready = 1'b0, get = 1'b0;
  logic err_valid = 1'b0, ext_valid = 1'b0;
  beri_cmd_t cmd = '0;
  logic [ERR_W-1:0] err_code = '0;
  logic [EVT_W-1:0] ext_code = '0;
  logic cmd_ready, reply_valid, sweep, ext_accept, test_start, test_done;
  beri_reply_t reply;
  logic [15:0] rom_bad, ram_bad, rom_set = '0, ram_set = '0;
  logic [3:0] t_delay = 4'h3;
  logic [4:0] pending;
  logic [31:0] lfsr = 32'h2873;
  int fail_count = 0, check_count = 0;
  beri_reply_t exp_q[$];
  logic [ERR_W-1:0] ecodes[7] = '{5'h09, 5'h05, 5'h04, 5'h06, 5'h0a, 5'h07, 5'h08};

  beri_top dut (.CLK_I(clk), .RST_N_I(rst_n), .CMD_VALID_I(cmd_valid), .CMD_I(cmd),
    .CMD_READY_O(cmd_ready), .REPLY_VALID_O(reply_valid), .REPLY_O(reply),
    .REPLY_READY_I(reply_ready), .GET_I(get), .SWEEP_START_O(sweep), .ERR_VALID_I(err_valid),
    .ERR_CODE_I(err_code), .EXT_EVT_VALID_I(ext_valid), .EXT_EVT_CODE_I(ext_code),
    .EXT_EVT_ACCEPT_O(ext_accept), .TEST_START_O(test_start), .TEST_DONE_I(test_done),
    .TEST_ROM_BAD_I(rom_bad), .TEST_RAM_BAD_I(ram_bad), .EVT_PENDING_O(pending));

  beri_test_engine_model partner (.clk_i(clk), .rst_n_i(rst_n), .start_i(test_start),
    .done_o(test_done), .rom_bad_o(rom_bad), .ram_bad_o(ram_bad), .delay_i(t_delay),
    .rom_mask_i(rom_set), .ram_mask_i(ram_set));

  always #2 clk = ~clk;

  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    lfsr_next = {x[30:0], 1'b0} ^ (x[31] ? 32'h04c1_1db7 : 32'h0);
  endfunction

  // ************************************************************
  // Checking
  // ************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Random stalls keep reply words standing for several cycles
  always @(posedge clk) begin
    lfsr <= lfsr_next(lfsr);
    reply_ready <= lfsr[0] | lfsr[3];
  end

  always @(posedge clk) begin
    if (rst_n && reply_valid === 1'b1 && reply_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(32'(reply), 32'hffff_ffff);
      end else begin
        check(32'(reply), 32'(exp_q.pop_front()));
      end
    end
  end

  // ************************************************************
  // Drivers
  // ************************************************************
  task automatic send(input beri_op_t op, input logic [15:0] arg);
    int n;
    n = 0;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd.op <= op;
    cmd.arg <= arg;
    do begin
      @(posedge clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 200);
    cmd_valid <= 1'b0;
    if (n >= 200) fail_count++;
  endtask

  task automatic query(input beri_op_t op, input beri_words_t w);
    int n;
    n = 0;
    foreach (w[i]) exp_q.push_back(beri_reply_t'{w[i], i == w.size() - 1});
    send(op, 16'h0000);
    while (exp_q.size() != 0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 2000) fail_count++;
    repeat (2) @(posedge clk);
  endtask

  task automatic trig(output int cnt);
    cnt = 0;
    @(posedge clk);
    get <= 1'b1;
    @(posedge clk);
    get <= 1'b0;
    repeat (3) begin
      @(posedge clk);
      if (sweep === 1'b1) cnt++;
    end
  endtask

  task automatic outside(input logic [7:0] code);
    int n;
    n = 0;
    @(posedge clk);
    ext_valid <= 1'b1;
    ext_code <= code;
    @(posedge clk);
    ext_valid <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (ext_accept !== 1'b1 && n < 4);
    check(32'(n < 4), 32'h1);
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    int cnt;
    logic [15:0] c0, c1, r, a;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    query(OP_Q_TRIG, '{16'h0001});
    trig(cnt);
    check(cnt, 1);
    send(OP_SET_TRIG, 16'h007f);
    query(OP_Q_TRIG, '{16'h0000});
    trig(cnt);
    check(cnt, 0);
    repeat (3) @(posedge clk);
    check(pending, 1);
    send(OP_SET_TRIG, 16'h0080);
    trig(cnt);
    check(cnt, 1);
    // Parser errors back to back, out of numeric order
    foreach (ecodes[i]) begin
      @(posedge clk);
      err_valid <= 1'b1;
      err_code <= ecodes[i];
    end
    @(posedge clk);
    err_valid <= 1'b0;
    repeat (3) @(posedge clk);
    check(pending, 8);
    query(OP_Q_EVENT, '{16'h00ce});
    check(pending, 7);
    query(OP_Q_ERR, '{16'h4, 16'h5, 16'h6, 16'h7, 16'h8, 16'h9, 16'ha});
    query(OP_Q_ERR, '{16'h0});
    send(OP_SET_EVENT_COUNT_SETTING, 16'h0380);
    query(OP_Q_EVENT_COUNT_SETTING, '{16'h3});
    query(OP_Q_EVENT_QUANTITY_QUERY, '{16'h3});
    query(OP_Q_ALL_EVENTS_QUERY, '{16'h6a, 16'h6c, 16'h6d});
    check(pending, 4);
    send(OP_SET_EVENT_COUNT_SETTING, 16'h0600);
    query(OP_Q_EVENT_QUANTITY_QUERY, '{16'h6});
    query(OP_Q_ALL_EVENTS_QUERY, '{16'h67, 16'h67, 16'h65, 16'h65, 16'h0, 16'h0});
    check(pending, 0);
    send(OP_SET_EVENT_COUNT_SETTING, 16'h0000);
    c0 = {8'h00, lfsr[7:0] | 8'h01};
    outside(c0[7:0]);
    c1 = {8'h00, lfsr[15:8] | 8'h01};
    outside(c1[7:0]);
    // Quantity asked before every variable-length reply
    query(OP_Q_EVENT_QUANTITY_QUERY, '{16'h2});
    query(OP_Q_ALL_EVENTS_QUERY, '{c0, c1});
    query(OP_Q_EVENT_QUANTITY_QUERY, '{16'h1});
    query(OP_Q_ALL_EVENTS_QUERY, '{16'h0});
    rom_set <= '0;
    ram_set <= '0;
    query(OP_Q_TEST, '{16'h0, 16'h0});
    r = lfsr[15:0];
    a = lfsr[31:16];
    rom_set <= r;
    ram_set <= a;
    t_delay <= 4'h9;
    query(OP_Q_TEST, '{r, a});
    final_report();
  end

  // Whole sequence needs a few hundred cycles
  initial begin
    #200000;
    fail_count++;
    final_report();
  end
endmodule
`default_nettype wire
